// *** src/operand_decoder_consts.vh ***
// operand field decoder constants: field positions, codes, bus offsets
// assumes inclusion by bare name from the decoder design files
`ifndef OPERAND_DECODER_CONSTS_VH
`define OPERAND_DECODER_CONSTS_VH

// address-mode byte fields
`define AM_MOD_HI       7
`define AM_MOD_LO       6
`define AM_MID_HI       5
`define AM_MID_LO       3
`define AM_LOW_HI       2
`define AM_LOW_LO       0

// fields register positions
`define FLD_AM_HI       7
`define FLD_AM_LO       0
`define FLD_SIB_HI      15
`define FLD_SIB_LO      8
`define FLD_OPSEL_HI    18
`define FLD_OPSEL_LO    16
`define FLD_SEG_HI      21
`define FLD_SEG_LO      19

// scale-index-base byte fields
`define SIB_BASE_HI     2
`define SIB_BASE_LO     0
`define SIB_IDX_HI      5
`define SIB_IDX_LO      3

// mode field codes
`define MOD_NO_DISP     2'h0
`define MOD_DISP8       2'h1
`define MOD_DISPFULL    2'h2
`define MOD_REGISTER    2'h3

// low field codes with special meaning
`define LOW_SIB_ESCAPE  3'h4
`define LOW_DIRECT16    3'h6

// segment codes (3-bit form; 2-bit form uses the low four)
`define SEG_EXTRA       3'h0
`define SEG_CODE        3'h1
`define SEG_STACK       3'h2
`define SEG_DATA        3'h3
`define SEG_EXTRA_F     3'h4
`define SEG_EXTRA_G     3'h5
`define SEG_RSVD_MIN    3'h6

// general registers
`define GR_BASE         3'h3
`define GR_BPTR         3'h5
`define GR_SRC          3'h6
`define GR_DST          3'h7
`define GR_NONE         3'h0

// displacement size codes
`define DISP_NONE       2'h0
`define DISP_8          2'h1
`define DISP_16         2'h2
`define DISP_32         2'h3

// register slice codes
`define SLICE_LOW8      2'h0
`define SLICE_HIGH8     2'h1
`define SLICE_16        2'h2
`define SLICE_32        2'h3

// selector source codes
`define SRC_OPCODE      2'h0
`define SRC_MID         2'h1
`define SRC_LOW         2'h2

// axi4-lite register byte offsets
`define REG_CTRL        8'h00
`define REG_FIELDS      8'h04
`define REG_RESULT      8'h08
`define REG_ADDRMODE    8'h0C

// control register bits
`define CTRL_SIZE_FLAG  0
`define CTRL_SIZE_PRES  1
`define CTRL_D_BIT      2
`define CTRL_LEGACY     3
`define CTRL_OPSZ_PFX   4
`define CTRL_ADSZ_PFX   5
`define CTRL_NO_AMBYTE  6
`define CTRL_MID_EXT    7
`define CTRL_SRC_LO     8
`define CTRL_SRC_HI     9

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define CTRL_RESET      32'h0000_0000

`endif

// *** src/register_slice_map.v ***
// one general register selector mapped to register number and slice
// assumes combinational use inside the operand decoder
`timescale 1ns/1ps
`include "operand_decoder_consts.vh"

module register_slice_map (
	// selector and width controls
	input  wire [2:0] sel_code,
	input  wire       size_present,
	input  wire       size_flag,
	input  wire       wide_op,
	// decoded register
	output reg  [2:0] reg_num,
	output reg  [1:0] reg_slice
);

	always @* begin
		reg_num = sel_code;
		reg_slice = wide_op ? `SLICE_32 : `SLICE_16;
		if (size_present && !size_flag) begin
			// byte form: upper codes reach high bytes of first four
			reg_num = {1'b0, sel_code[1:0]};
			reg_slice = sel_code[2] ? `SLICE_HIGH8 : `SLICE_LOW8;
		end
	end

endmodule

// *** src/operand_field_decoder.v ***
// operand field decoder: turns opcode/address-mode fields into selections
// assumes an axi4-lite master loads the fields and reads the decode back
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "operand_decoder_consts.vh"

module operand_field_decoder (
	// clock, enable, reset
	input  wire        core_clk,
	input  wire        clk_en,
	input  wire        nrst,
	// axi4-lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	// ---------------------------------------------------------------
	// software registers
	// ---------------------------------------------------------------
	reg  [31:0] ctrl_ff;
	reg  [31:0] fields_ff;
	reg  [31:0] result_ff;
	reg  [31:0] addrmode_ff;
	reg         aw_held_ff;
	reg         w_held_ff;
	reg  [7:0]  aw_addr_ff;
	reg  [31:0] w_data_ff;
	reg  [3:0]  w_strb_ff;

	// fields register: [7:0] address-mode byte, [15:8] sib byte,
	// [18:16] opcode selector, [21:19] three-bit segment code
	wire [7:0]  am_byte = fields_ff[`FLD_AM_HI:`FLD_AM_LO];
	wire [7:0]  sib_byte = fields_ff[`FLD_SIB_HI:`FLD_SIB_LO];
	wire [2:0]  op_sel = fields_ff[`FLD_OPSEL_HI:`FLD_OPSEL_LO];
	wire [2:0]  seg_code = fields_ff[`FLD_SEG_HI:`FLD_SEG_LO];
	wire [1:0]  am_mod = am_byte[`AM_MOD_HI:`AM_MOD_LO];
	wire [2:0]  am_mid = am_byte[`AM_MID_HI:`AM_MID_LO];
	wire [2:0]  am_low = am_byte[`AM_LOW_HI:`AM_LOW_LO];
	wire [1:0]  src_sel = ctrl_ff[`CTRL_SRC_HI:`CTRL_SRC_LO];

	// ---------------------------------------------------------------
	// combinational decode
	// ---------------------------------------------------------------
	// default width: legacy modes force 16, prefixes toggle
	wire        dflt_wide = ctrl_ff[`CTRL_D_BIT] & ~ctrl_ff[`CTRL_LEGACY];
	wire        wide_op = dflt_wide ^ ctrl_ff[`CTRL_OPSZ_PFX];
	wire        wide_addr = dflt_wide ^ ctrl_ff[`CTRL_ADSZ_PFX];
	wire        am_used = ~ctrl_ff[`CTRL_NO_AMBYTE];
	wire        mid_is_ext = ctrl_ff[`CTRL_MID_EXT];
	wire        mem_form = am_mod != `MOD_REGISTER;

	reg  [2:0]  sel_code;
	reg         sel_valid;
	reg  [2:0]  seg_sel;
	reg         seg_bad;
	reg         sib_follows;
	reg  [2:0]  base_a;
	reg  [2:0]  base_b;
	reg         base_a_ok;
	reg         base_b_ok;
	reg  [1:0]  disp_size;
	reg  [2:0]  dflt_seg;
	wire [2:0]  reg_num;
	wire [1:0]  reg_slice;

	always @* begin
		sel_code = op_sel;
		sel_valid = 1'b1;
		case (src_sel)
			`SRC_OPCODE: sel_code = op_sel;
			`SRC_MID: begin
				// an opcode extension in the middle field names no register
				sel_code = am_mid;
				sel_valid = am_used & ~mid_is_ext;
			end
			`SRC_LOW: begin
				sel_code = am_low;
				// low field names a register only in mode 11
				sel_valid = am_used & ~mem_form;
			end
			default: sel_valid = 1'b0;
		endcase
	end

	register_slice_map u_slice (
		.sel_code     (sel_code),
		.size_present (ctrl_ff[`CTRL_SIZE_PRES]),
		.size_flag    (ctrl_ff[`CTRL_SIZE_FLAG]),
		.wide_op      (wide_op),
		.reg_num      (reg_num),
		.reg_slice    (reg_slice)
	);

	// segment selection, reserved codes flagged
	// reserved codes fall back to the data segment so nothing downstream
	// sees an undefined selection; the invalid flag carries the fault
	always @* begin
		seg_sel = seg_code;
		seg_bad = seg_code >= `SEG_RSVD_MIN;
		if (seg_bad)
			seg_sel = `SEG_DATA;
	end

	always @* begin
		sib_follows = 1'b0;
		base_a = `GR_NONE;
		base_b = `GR_NONE;
		base_a_ok = 1'b0;
		base_b_ok = 1'b0;
		disp_size = `DISP_NONE;
		dflt_seg = `SEG_DATA;
		if (am_used && mem_form) begin
			if (wide_addr) begin
				// sib escape: index and base read from sib byte; scale bits unused
				sib_follows = am_low == `LOW_SIB_ESCAPE;
				base_a = sib_follows ? sib_byte[`SIB_BASE_HI:`SIB_BASE_LO] : am_low;
				base_a_ok = 1'b1;
				base_b = sib_byte[`SIB_IDX_HI:`SIB_IDX_LO];
				base_b_ok = sib_follows & (sib_byte[`SIB_IDX_HI:`SIB_IDX_LO] != `LOW_SIB_ESCAPE);
				disp_size = (am_mod == `MOD_DISP8) ? `DISP_8 :
				            (am_mod == `MOD_DISPFULL) ? `DISP_32 : `DISP_NONE;
				// base pointer code with no displacement is a bare 32-bit offset
				if (am_mod == `MOD_NO_DISP && base_a == `GR_BPTR) begin
					base_a_ok = 1'b0;
					disp_size = `DISP_32;
				end
				if (base_a_ok && (base_a == `GR_BPTR || base_a == `LOW_SIB_ESCAPE))
					dflt_seg = `SEG_STACK;
			end else begin
				// 16-bit table: pairs then singles
				base_a_ok = 1'b1;
				base_b_ok = ~am_low[2];
				case (am_low)
					3'h0, 3'h1: base_a = `GR_BASE;
					3'h2, 3'h3: base_a = `GR_BPTR;
					3'h4: base_a = `GR_SRC;
					3'h5: base_a = `GR_DST;
					3'h6: base_a = `GR_BPTR;
					default: base_a = `GR_BASE;
				endcase
				base_b = am_low[0] ? `GR_DST : `GR_SRC;
				disp_size = (am_mod == `MOD_DISP8) ? `DISP_8 :
				            (am_mod == `MOD_DISPFULL) ? `DISP_16 : `DISP_NONE;
				if (am_mod == `MOD_NO_DISP && am_low == `LOW_DIRECT16) begin
					base_a_ok = 1'b0;
					disp_size = `DISP_16;
				end
				if (base_a_ok && base_a == `GR_BPTR)
					dflt_seg = `SEG_STACK;
			end
		end
	end

	// ---------------------------------------------------------------
	// axi4-lite slave; one cycle from both halves taken to bvalid
	// ---------------------------------------------------------------
	wire        do_write = aw_held_ff & w_held_ff & ~s_axi_bvalid;
	wire [31:0] nxt_wmerge;
	reg  [31:0] wtarget;

	// merge base: the register that the held write is aimed at
	always @* begin
		case (aw_addr_ff)
			`REG_CTRL:   wtarget = ctrl_ff;
			default:     wtarget = fields_ff;
		endcase
	end

	// byte-lane merge, one lane per strobe bit
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
			assign nxt_wmerge[gi*8+7:gi*8] = w_strb_ff[gi] ? w_data_ff[gi*8+7:gi*8] : wtarget[gi*8+7:gi*8];
		end
	endgenerate

	// write channels and register update
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
			ctrl_ff <= `CTRL_RESET;
			fields_ff <= 32'h0000_0000;
		end else if (clk_en) begin
			// ready drops the cycle after a take so a held half is never
			// overwritten before its partner arrives
			s_axi_awready <= ~aw_held_ff & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready <= ~w_held_ff & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				if (aw_addr_ff == `REG_CTRL)
					ctrl_ff <= nxt_wmerge;
				else if (aw_addr_ff == `REG_FIELDS)
					fields_ff <= nxt_wmerge;
				else
					s_axi_bresp <= `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// decode results registered so reads see a settled value
	// costs one cycle of lag after a write; software reads after bresp
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			result_ff <= 32'h0000_0000;
			addrmode_ff <= 32'h0000_0000;
		end else if (clk_en) begin
			result_ff <= {19'h00000, wide_addr, wide_op, seg_bad, seg_sel,
			              sel_valid, mem_form & am_used, reg_slice, reg_num};
			addrmode_ff <= {17'h00000, sib_follows, dflt_seg, disp_size,
			                base_b_ok, base_b, base_a_ok, base_a, am_used};
		end
	end

	// read channel: answer one cycle after address taken
	// address decoded at the take; rdata then stands until rready
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (clk_en) begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				case (s_axi_araddr)
					`REG_CTRL:     s_axi_rdata <= ctrl_ff;
					`REG_FIELDS:   s_axi_rdata <= fields_ff;
					`REG_RESULT:   s_axi_rdata <= result_ff;
					`REG_ADDRMODE: s_axi_rdata <= addrmode_ff;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// *** verif/host_bus_model.sv ***
// host model: lite bus master standing in for fetch logic
// assumes one clock shared with the decoder
`timescale 1ns/1ps
module host_bus_model (
	// clock
	input  wire        core_clk,
	// write side
	output reg  [7:0]  awaddr,
	output reg         awvalid,
	input  wire        awready,
	output reg  [31:0] wdata,
	output reg         wvalid,
	input  wire        wready,
	input  wire [1:0]  bresp,
	input  wire        bvalid,
	output reg         bready,
	// read side
	output reg  [7:0]  araddr,
	output reg         arvalid,
	input  wire        arready,
	input  wire [31:0] rdata,
	input  wire [1:0]  rresp,
	input  wire        rvalid,
	output reg         rready,
	// hang flag
	output reg         tmo
);
	// ---------------------------
	// bus cycles
	// ---------------------------
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready, tmo} = '0;
	end
	// each channel holds until its own ready; waits are bounded
	task automatic wr(input [7:0] a, input [31:0] v, output [1:0] r);
		int n;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 50)
			tmo <= 1'b1;
	endtask
	// read: address held until taken, rready up until data seen
	task automatic rd(input [7:0] a, output [31:0] v, output [1:0] r);
		int n;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				v = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 50)
			tmo <= 1'b1;
	endtask
endmodule

// *** verif/operand_field_checker.sv ***
// checker: bus timing and decode readback relations
// assumes bind onto the decoder top
`timescale 1ns/1ps
`include "operand_decoder_consts.vh"
module operand_field_checker (
	// clock, reset
	input wire        core_clk,
	input wire        clk_en,
	input wire        nrst,
	// bus
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [7:0]  s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready
);
	// ---------------------------
	// relations
	// ---------------------------
	reg  [7:0] ra_ff;
	wire       res_ok;
	wire       am_ok;
	// remember the read offset so readback fields can be judged
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			ra_ff <= 8'h00;
		else if (s_axi_arvalid && s_axi_arready && clk_en)
			ra_ff <= s_axi_araddr;
	end
	assign res_ok = s_axi_rvalid && s_axi_rresp == `RESP_OKAY && ra_ff == `REG_RESULT;
	assign am_ok  = s_axi_rvalid && s_axi_rresp == `RESP_OKAY && ra_ff == `REG_ADDRMODE;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence ar_take;
		s_axi_arvalid && s_axi_arready && clk_en;
	endsequence
	chk_read_answer:
		assert property (ar_take |=> s_axi_rvalid) else $error("read not answered");
	chk_rdata_hold:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
			else $error("read data dropped");
	chk_bvalid_hold:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("response dropped");
	chk_ar_block:
		assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken while busy");
	chk_high_byte:
		assert property (res_ok && s_axi_rdata[4:3] == 2'h1 |-> !s_axi_rdata[2]) else $error("bad high byte");
	chk_slice_width:
		assert property (res_ok && s_axi_rdata[4] |-> s_axi_rdata[11] == s_axi_rdata[3])
			else $error("slice width mismatch");
	chk_seg_range:
		assert property (res_ok |-> s_axi_rdata[9:7] <= 3'h5) else $error("segment out of range");
	chk_invalid_seg:
		assert property (res_ok && s_axi_rdata[10] |-> s_axi_rdata[9:7] == 3'h3) else $error("invalid seg shown");
	chk_sib_byte:
		assert property (am_ok && s_axi_rdata[14] |-> s_axi_rdata[0]) else $error("sib without mode byte");
endmodule
bind operand_field_decoder operand_field_checker u_chk (.core_clk(core_clk), .clk_en(clk_en), .nrst(nrst),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** verif/operand_field_decoder_tb.sv ***
// bench: decoder driven over the lite bus by the host model
// assumes src on the include path, 100 MHz clock
`timescale 1ns/1ps
`include "operand_decoder_consts.vh"
module operand_field_decoder_tb;
	// ---------------------------
	// wiring and scenarios
	// ---------------------------
	logic       core_clk = 1'b0;
	logic       nrst     = 1'b0;
	logic       run_en   = 1'b1;
	logic [31:0] d;
	logic [1:0] r;
	int         fails      = 0;
	int         n_compared = 0;
	wire [31:0] wdata, rdata;
	wire [7:0]  awaddr, araddr;
	wire [1:0]  bresp, rresp;
	wire        awvalid, awready, wvalid, wready, bvalid, bready;
	wire        arvalid, arready, rvalid, rready, tmo;
	always #5 core_clk = ~core_clk;
	operand_field_decoder DUT (.core_clk(core_clk), .clk_en(run_en), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	host_bus_model u_host (.core_clk(core_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .tmo(tmo));
	task automatic chk(input [31:0] got, input [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// a hung bus cycle ends the run
	always @(posedge core_clk) begin
		if (tmo === 1'b1) begin
			fails++;
			summarize;
		end
	end
	// reset value, read-only and unmapped offsets
	task automatic t_bus;
		u_host.rd(`REG_CTRL, d, r);
		chk(d, `CTRL_RESET);
		u_host.wr(`REG_RESULT, 32'h1, r);
		chk({30'h0, r}, {30'h0, `RESP_SLVERR});
		u_host.rd(8'h10, d, r);
		chk({30'h0, r}, {30'h0, `RESP_SLVERR});
	endtask
	// every selector code, the three valid sources, size flag form and width
	task automatic t_reg;
		int i;
		logic [2:0] n, s, num;
		logic [1:0] f, sl;
		logic       wide;
		for (i = 0; i < 192; i++) begin
			n = i[2:0];
			f = i[4:3];
			wide = i[5];
			s = 3'(i / 64);
			u_host.wr(`REG_CTRL, {22'h0, s[1:0], 3'h0, wide, 2'h2, f == 2'h1 || f == 2'h2, f == 2'h2}, r);
			u_host.wr(`REG_FIELDS, {13'h0, s == 0 ? n : ~n, 10'h3, s == 1 ? n : ~n, s == 2 ? n : ~n}, r);
			num = (f == 2'h1) ? {1'b0, n[1:0]} : n;
			sl = (f == 2'h1) ? {1'b0, n[2]} : (wide ? 2'h3 : 2'h2);
			u_host.rd(`REG_RESULT, d, r);
			chk(d & 32'h1FFF, {19'h0, 1'b0, wide, 4'h0, 2'h2, sl, num});
		end
	endtask
	// all segment codes, then implied addressing
	task automatic t_seg;
		int i;
		for (i = 0; i < 8; i++) begin
			u_host.wr(`REG_FIELDS, {10'h0, i[2:0], 19'h0}, r);
			u_host.rd(`REG_RESULT, d, r);
			chk({28'h0, d[10:7]}, {28'h0, i > 5, i > 5 ? 3'h3 : i[2:0]});
		end
		u_host.wr(`REG_CTRL, 32'h48, r);
		u_host.rd(`REG_ADDRMODE, d, r);
		chk({31'h0, d[0]}, 32'h0);
	endtask
	// 16-bit address table: bases, displacement, default segment
	task automatic t_am16;
		int i;
		logic [1:0]  md, dp;
		logic [2:0]  lo, sg;
		logic        av, bv;
		logic [14:0] m, e;
		u_host.wr(`REG_CTRL, 32'h8, r);
		for (i = 0; i < 24; i++) begin
			md = i[4:3];
			lo = i[2:0];
			av = !(md == 2'h0 && lo == 3'h6);
			bv = lo < 3'h4;
			dp = md == 2'h0 ? (av ? 2'h0 : 2'h2) : md;
			sg = (lo == 3'h2 || lo == 3'h3 || (lo == 3'h6 && av)) ? 3'h2 : 3'h3;
			m = 15'h7F11 | (av ? 15'h000E : 15'h0) | (bv ? 15'h00E0 : 15'h0);
			e = {1'b0, sg, dp, bv, 3'(12'hFBE >> (lo[1:0] * 3)), av, 3'(24'h77EB5B >> (lo * 3)), 1'b1};
			u_host.wr(`REG_FIELDS, {24'h0, md, 3'h0, lo}, r);
			u_host.rd(`REG_ADDRMODE, d, r);
			chk({17'h0, d[14:0] & m}, {17'h0, e & m});
		end
	endtask
	// 32-bit addressing: scale-index-base byte presence and its fields
	task automatic t_sib;
		int i;
		logic sb;
		u_host.wr(`REG_CTRL, 32'h4, r);
		for (i = 0; i < 8; i++) begin
			sb = !i[2] && i[1:0] != 2'h3;
			u_host.wr(`REG_FIELDS, {16'h0, 8'h0E, i[1:0], 3'h0, i[2] ? 3'h5 : 3'h4}, r);
			u_host.rd(`REG_ADDRMODE, d, r);
			chk({31'h0, d[14]}, {31'h0, sb});
			if (sb)
				chk({24'h0, d[8:1]}, {24'h0, 1'b1, 3'h1, 1'b1, 3'h6});
		end
	endtask
	// middle field as opcode extension, low field in memory form, bad source
	task automatic t_ext;
		u_host.wr(`REG_FIELDS, 32'h0, r);
		u_host.wr(`REG_CTRL, 32'h180, r);
		u_host.rd(`REG_RESULT, d, r);
		chk({31'h0, d[6]}, 32'h0);
		u_host.wr(`REG_CTRL, 32'h100, r);
		u_host.rd(`REG_RESULT, d, r);
		chk({31'h0, d[6]}, 32'h1);
		u_host.wr(`REG_CTRL, 32'h200, r);
		u_host.rd(`REG_RESULT, d, r);
		chk({30'h0, d[6:5]}, 32'h1);
		u_host.wr(`REG_CTRL, 32'h300, r);
		u_host.rd(`REG_RESULT, d, r);
		chk({31'h0, d[6]}, 32'h0);
	endtask
	// clock enable low holds a taken write: no response until it returns
	task automatic t_freeze;
		fork
			u_host.wr(`REG_FIELDS, 32'h0012_3456, r);
			begin
				repeat (2) @(posedge core_clk);
				run_en <= 1'b0;
				repeat (10) @(posedge core_clk);
				chk({31'h0, bvalid}, 32'h0);
				run_en <= 1'b1;
			end
		join
		u_host.rd(`REG_FIELDS, d, r);
		chk(d, 32'h0012_3456);
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge core_clk);
		t_bus;
		t_reg;
		t_seg;
		t_ext;
		t_am16;
		t_sib;
		t_freeze;
		summarize;
	end
endmodule
